// file: rtl/tpc_divider.v
`timescale 1ns/1ps
`default_nettype none
// Prescaler (1/4/16/64) followed by a 5-bit scaler dividing by value+1
module tpc_divider (
	input  wire       i_sys_clk,
	input  wire       i_nrst,
	input  wire       i_tick,
	input  wire [1:0] i_pre,
	input  wire [4:0] i_scale,
	output reg        o_tick
);
	reg [5:0] pre_cnt;
	reg [4:0] scl_cnt;
	reg [5:0] pre_last;
	always @* begin
		case (i_pre)
			2'h0:    pre_last = 6'h00;
			2'h1:    pre_last = 6'h03;
			2'h2:    pre_last = 6'h0f;
			default: pre_last = 6'h3f;
		endcase
	end
	wire pre_done = i_tick && (pre_cnt >= pre_last);
	always @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pre_cnt <= 6'h00;
			scl_cnt <= 5'h00;
			o_tick  <= 1'b0;
		end else begin
			o_tick <= 1'b0;
			if (i_tick)
				pre_cnt <= pre_done ? 6'h00 : pre_cnt + 6'h01;
			if (pre_done) begin
				if (scl_cnt >= i_scale) begin
					scl_cnt <= 5'h00;
					o_tick  <= 1'b1;
				end else
					scl_cnt <= scl_cnt + 5'h01;
			end
		end
	end
endmodule // tpc_divider
`default_nettype wire

// file: rtl/tpc_regs.vh
`ifndef TPC_REGS_VH
`define TPC_REGS_VH
// Register indices; byte address is four times the index
`define TPC_IDX_BOUND      8'h09
`define TPC_IDX_SCALING    8'h17
`define TPC_IDX_CMP_SEL    8'h19
`define TPC_IDX_CTRL       8'h1c
`define TPC_IDX_COUNT      8'h1d
`define TPC_IDX_CMP_CTRL   8'h18
`define TPC_IDX_STATUS     8'h1f
`define TPC_RESET_VAL      8'h00
// Control field positions
`define TPC_CTRL_SRC_HI    7
`define TPC_CTRL_SRC_LO    4
`define TPC_CTRL_OUT_HI    3
`define TPC_CTRL_OUT_LO    2
`define TPC_CTRL_MODE      1
`define TPC_CTRL_INV       0
// Scaling field positions
`define TPC_SCL_RES        7
`define TPC_SCL_PRE_HI     6
`define TPC_SCL_PRE_LO     5
`define TPC_SCL_DIV_HI     4
`define TPC_SCL_DIV_LO     0
// Comparator selection and control bits
`define TPC_CSEL_TO_PA0    7
`define TPC_CSEL_WAKE      6
`define TPC_CCTL_RESAMPLE  5
// Clock source codes
`define TPC_SRC_OFF        4'h0
`define TPC_SRC_SYS        4'h1
`define TPC_SRC_FAST       4'h2
`define TPC_SRC_SLOW       4'h4
`define TPC_SRC_CMP        4'h5
`define TPC_SRC_ALT_SLOW   4'h6
`define TPC_SRC_PA0_RISE   4'h8
`define TPC_SRC_PA0_FALL   4'h9
`define TPC_SRC_PA4_RISE   4'hc
`define TPC_SRC_PA4_FALL   4'hd
// Output routing codes
`define TPC_OUT_OFF        2'h0
`define TPC_OUT_PA3        2'h2
`define TPC_OUT_PA4        2'h3
`endif

// file: rtl/tpc_sync_edge.v
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser with rise and fall pulses taken from the second stage
module tpc_sync_edge (
	input  wire i_sys_clk,
	input  wire i_nrst,
	input  wire i_async,
	output wire o_level,
	output wire o_rise,
	output wire o_fall
);
	reg meta;
	reg stable;
	reg prev;
	always @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			meta   <= 1'b0;
			stable <= 1'b0;
			prev   <= 1'b0;
		end else begin
			meta   <= i_async;
			stable <= meta;
			prev   <= stable;
		end
	end
	assign o_level = stable;
	assign o_rise  = stable & ~prev;
	assign o_fall  = ~stable & prev;
endmodule // tpc_sync_edge
`default_nettype wire

// file: rtl/tpc_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "tpc_regs.vh"
// Notes on behaviour
// - Source codes 0,1,2,4,5,6 pick stopped, system, fast, slow, comparator, alt slow.
// - Codes 8/9 count PA0 rise/fall, 12/13 count PA4 rise/fall, rest reserved.
// - Output routing 00 none, 01 reserved, 10 port A bit 3, 11 bit 4.
// - Control bit 1 chooses period mode when clear, PWM when set.
// - Control bit 0 inverts the timer output polarity.
// - Scaling bit 7 picks 8-bit PWM, or 6/7-bit by build option.
// - Prescaler 1/4/16/64 from bits 6-5, then 5-bit scaler from bits 4-0.
// - Timer count readable and writable, resets to zero.
// - Write-only 8-bit bound compared against the counter, resets to zero.
// - Comparator selection bit 7 routes comparator result onto port A bit 0.
// - Comparator selection bit 6 enables wake-up on comparator level change.
// - Comparator control bit chooses resampling by timer tick or raw pass.
module tpc_timer #(
	parameter FAST_OSC_DOUBLE_OPTION = 0,
	parameter PWM_WIDTH_OPTION       = 0
) (
	input  wire        i_sys_clk,
	input  wire        i_nrst,
	input  wire [7:0]  i_avs_address,
	input  wire        i_avs_read,
	input  wire        i_avs_write,
	input  wire [31:0] i_avs_writedata,
	input  wire [3:0]  i_avs_byteenable,
	output reg  [31:0] o_avs_readdata,
	output reg         o_avs_waitrequest,
	input  wire        i_fast_internal_osc,
	input  wire        i_fast_osc_x2,
	input  wire        i_slow_internal_osc,
	input  wire        i_alt_slow_osc,
	input  wire        i_cmp_result,
	input  wire        i_port_a_bit_zero,
	input  wire        i_port_a_bit_four,
	output reg         o_port_a_bit_zero,
	output reg         o_port_a_bit_zero_oe_n,
	output reg         o_port_a_bit_three,
	output reg         o_port_a_bit_three_oe_n,
	output reg         o_port_a_bit_four,
	output reg         o_port_a_bit_four_oe_n,
	output reg         o_wake
);
	reg  [7:0] timer_control;
	reg  [7:0] timer_scaling;
	reg  [7:0] timer_bound;
	reg  [7:0] timer_count;
	reg  [7:0] comparator_selection;
	reg  [7:0] comparator_control;
	reg        tm_out;
	reg        cmp_held;
	reg        cmp_last;
	reg        bus_done;
	reg        timer_tick;
	wire       fast_r, slow_r, alt_r, x2_r;
	wire       cmp_lvl, cmp_r, pa0_r, pa0_f, pa4_r, pa4_f;
	wire       scaled_tick;

	tpc_sync_edge u_fast (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_async(i_fast_internal_osc),
		.o_level(), .o_rise(fast_r), .o_fall());
	tpc_sync_edge u_x2 (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_async(i_fast_osc_x2),
		.o_level(), .o_rise(x2_r), .o_fall());
	tpc_sync_edge u_slow (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_async(i_slow_internal_osc),
		.o_level(), .o_rise(slow_r), .o_fall());
	tpc_sync_edge u_alt (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_async(i_alt_slow_osc),
		.o_level(), .o_rise(alt_r), .o_fall());
	tpc_sync_edge u_cmp (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_async(i_cmp_result),
		.o_level(cmp_lvl), .o_rise(cmp_r), .o_fall());
	tpc_sync_edge u_pa0 (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_async(i_port_a_bit_zero),
		.o_level(), .o_rise(pa0_r), .o_fall(pa0_f));
	tpc_sync_edge u_pa4 (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_async(i_port_a_bit_four),
		.o_level(), .o_rise(pa4_r), .o_fall(pa4_f));

	wire [3:0] src   = timer_control[`TPC_CTRL_SRC_HI:`TPC_CTRL_SRC_LO];
	wire [1:0] route = timer_control[`TPC_CTRL_OUT_HI:`TPC_CTRL_OUT_LO];
	wire       pwm   = timer_control[`TPC_CTRL_MODE];
	wire       inv   = timer_control[`TPC_CTRL_INV];

	// Oscillators are sampled, so their rate must stay well below half the system clock
	always @* begin
		case (src)
			`TPC_SRC_SYS:      timer_tick = 1'b1;
			`TPC_SRC_FAST:     timer_tick = (FAST_OSC_DOUBLE_OPTION != 0) ? x2_r : fast_r;
			`TPC_SRC_SLOW:     timer_tick = slow_r;
			`TPC_SRC_CMP:      timer_tick = cmp_r;
			`TPC_SRC_ALT_SLOW: timer_tick = alt_r;
			`TPC_SRC_PA0_RISE: timer_tick = pa0_r;
			`TPC_SRC_PA0_FALL: timer_tick = pa0_f;
			`TPC_SRC_PA4_RISE: timer_tick = pa4_r;
			`TPC_SRC_PA4_FALL: timer_tick = pa4_f;
			default:           timer_tick = 1'b0;
		endcase
	end

	tpc_divider u_div (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_tick(timer_tick),
		.i_pre(timer_scaling[`TPC_SCL_PRE_HI:`TPC_SCL_PRE_LO]),
		.i_scale(timer_scaling[`TPC_SCL_DIV_HI:`TPC_SCL_DIV_LO]),
		.o_tick(scaled_tick)
	);

	// PWM counter wraps at the resolution's top value
	reg [7:0] pwm_top;
	always @* begin
		if (!timer_scaling[`TPC_SCL_RES])
			pwm_top = 8'hff;
		else if (PWM_WIDTH_OPTION != 0)
			pwm_top = 8'h7f;
		else
			pwm_top = 8'h3f;
	end

	function [7:0] tpc_byte;
		input [31:0] data;
		input [3:0]  be;
		input [7:0]  old;
		begin
			tpc_byte = be[0] ? data[7:0] : old;
		end
	endfunction

	wire [7:0] idx   = i_avs_address;
	// A write lands at the edge where the master sees waitrequest low, not before
	wire       wr_go = i_avs_write && bus_done;
	wire       rd_go = i_avs_read && !bus_done;
	wire       bound_hit = (timer_count == timer_bound);

	// Bus answers one cycle after the request is seen; a count write beats a timer tick
	always @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			timer_control        <= `TPC_RESET_VAL;
			timer_scaling        <= `TPC_RESET_VAL;
			timer_bound          <= `TPC_RESET_VAL;
			timer_count          <= `TPC_RESET_VAL;
			comparator_selection <= `TPC_RESET_VAL;
			comparator_control   <= `TPC_RESET_VAL;
			tm_out               <= 1'b0;
			bus_done             <= 1'b0;
			o_avs_readdata       <= 32'h0000_0000;
			o_avs_waitrequest    <= 1'b1;
		end else begin
			bus_done          <= (i_avs_read || i_avs_write) && !bus_done;
			o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !bus_done);
			if (scaled_tick) begin
				if (pwm) begin
					timer_count <= (timer_count >= pwm_top) ? 8'h00 : timer_count + 8'h01;
				end else if (bound_hit) begin
					timer_count <= 8'h00;
					tm_out      <= ~tm_out;
				end else
					timer_count <= timer_count + 8'h01;
			end
			if (pwm)
				tm_out <= ((timer_count & pwm_top) < timer_bound);
			if (wr_go) begin
				if (idx == `TPC_IDX_CTRL)
					timer_control <= tpc_byte(i_avs_writedata, i_avs_byteenable, timer_control);
				else if (idx == `TPC_IDX_SCALING)
					timer_scaling <= tpc_byte(i_avs_writedata, i_avs_byteenable, timer_scaling);
				else if (idx == `TPC_IDX_BOUND)
					timer_bound <= tpc_byte(i_avs_writedata, i_avs_byteenable, timer_bound);
				else if (idx == `TPC_IDX_COUNT)
					timer_count <= tpc_byte(i_avs_writedata, i_avs_byteenable, timer_count);
				else if (idx == `TPC_IDX_CMP_SEL)
					comparator_selection <= tpc_byte(i_avs_writedata, i_avs_byteenable, comparator_selection);
				else if (idx == `TPC_IDX_CMP_CTRL)
					comparator_control <= tpc_byte(i_avs_writedata, i_avs_byteenable, comparator_control);
			end
			o_avs_readdata <= 32'h0000_0000;
			if (rd_go) begin
				if (idx == `TPC_IDX_CTRL)
					o_avs_readdata <= {24'h00_0000, timer_control};
				else if (idx == `TPC_IDX_COUNT)
					o_avs_readdata <= {24'h00_0000, timer_count};
				else if (idx == `TPC_IDX_CMP_CTRL)
					o_avs_readdata <= {24'h00_0000, comparator_control};
				else if (idx == `TPC_IDX_STATUS)
					o_avs_readdata <= {24'h00_0000, 6'h00, cmp_held, tm_out};
			end
		end
	end

	// Resampled comparator only moves on a timer tick
	always @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cmp_held <= 1'b0;
			cmp_last <= 1'b0;
		end else begin
			if (!comparator_control[`TPC_CCTL_RESAMPLE])
				cmp_held <= cmp_lvl;
			else if (timer_tick)
				cmp_held <= cmp_lvl;
			cmp_last <= cmp_held;
		end
	end

	always @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_port_a_bit_zero       <= 1'b0;
			o_port_a_bit_zero_oe_n  <= 1'b1;
			o_port_a_bit_three      <= 1'b0;
			o_port_a_bit_three_oe_n <= 1'b1;
			o_port_a_bit_four       <= 1'b0;
			o_port_a_bit_four_oe_n  <= 1'b1;
			o_wake                  <= 1'b0;
		end else begin
			o_port_a_bit_zero      <= cmp_held;
			o_port_a_bit_zero_oe_n <= !comparator_selection[`TPC_CSEL_TO_PA0];
			o_port_a_bit_three      <= tm_out ^ inv;
			o_port_a_bit_three_oe_n <= (route != `TPC_OUT_PA3);
			o_port_a_bit_four       <= tm_out ^ inv;
			o_port_a_bit_four_oe_n  <= (route != `TPC_OUT_PA4);
			o_wake <= comparator_selection[`TPC_CSEL_WAKE] && (cmp_held != cmp_last);
		end
	end
endmodule // tpc_timer
`default_nettype wire

// file: testbench/tpc_pins.sv
`timescale 1ns/1ps
`default_nettype none
// Comparator and two port A pins; a pin shows the block's level only while it drives
module tpc_pins (
	input  wire logic i_sys_clk,
	input  wire logic i_pa0_out,
	input  wire logic i_pa0_oe_n,
	input  wire logic i_pa4_out,
	input  wire logic i_pa4_oe_n,
	output wire logic o_pa0,
	output wire logic o_pa4,
	output var  logic o_cmp
);
	logic pa0_ext = 1'b0;
	logic pa4_ext = 1'b0;
	initial o_cmp = 1'b0;
	assign o_pa0 = i_pa0_oe_n ? pa0_ext : i_pa0_out;
	assign o_pa4 = i_pa4_oe_n ? pa4_ext : i_pa4_out;
	// Slow toggles so the two-flop synchroniser never misses a level
	task automatic pulse(input int sel, input int n);
		repeat (2 * n) begin
			repeat (4) @(posedge i_sys_clk);
			if (sel == 0) pa0_ext <= ~pa0_ext;
			else if (sel == 1) pa4_ext <= ~pa4_ext;
			else o_cmp <= ~o_cmp;
		end
	endtask
	task automatic set_cmp(input logic v);
		o_cmp <= v;
	endtask
endmodule // tpc_pins
`default_nettype wire

// file: testbench/tpc_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tpc_sva (
	input wire logic        i_sys_clk,
	input wire logic        i_nrst,
	input wire logic [7:0]  i_avs_address,
	input wire logic        i_avs_read,
	input wire logic        i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic        o_avs_waitrequest,
	input wire logic        o_port_a_bit_zero_oe_n,
	input wire logic        o_port_a_bit_three_oe_n,
	input wire logic        o_port_a_bit_four_oe_n,
	input wire logic        o_wake
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	chk_wait_one: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low too long");
	chk_wait_answer: assert property ($rose(i_avs_read | i_avs_write) |=> !o_avs_waitrequest)
		else $error("answer late");
	chk_rdata_idle: assert property (o_avs_waitrequest |-> o_avs_readdata == 32'h0000_0000)
		else $error("read data outside answer");
	chk_rdata_upper: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	chk_route_excl: assert property (!(!o_port_a_bit_three_oe_n && !o_port_a_bit_four_oe_n))
		else $error("both timer pins driven");
	chk_wake_pulse: assert property (o_wake |=> !o_wake)
		else $error("wake longer than a cycle");
	chk_wo_read: assert property (i_avs_read && !o_avs_waitrequest && (i_avs_address == 8'h09 ||
		i_avs_address == 8'h17 || i_avs_address == 8'h19) |-> o_avs_readdata == 32'h0000_0000)
		else $error("write-only register readable");
	chk_reset_oe: assert property (!$past(i_nrst) |-> o_port_a_bit_zero_oe_n && o_port_a_bit_three_oe_n &&
		o_port_a_bit_four_oe_n) else $error("pin driven after reset");
endmodule // tpc_sva
bind tpc_timer tpc_sva i_sva (.i_sys_clk, .i_nrst, .i_avs_address, .i_avs_read, .i_avs_write, .o_avs_readdata,
	.o_avs_waitrequest, .o_port_a_bit_zero_oe_n, .o_port_a_bit_three_oe_n, .o_port_a_bit_four_oe_n, .o_wake);
`default_nettype wire

// file: testbench/tpc_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tpc_timer_tb;
	logic        clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0, fast = 1'b0, slow = 1'b0, alt = 1'b0, x2 = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0]  be = 4'hf;
	wire  [31:0] rdata;
	wire         waitreq, pa0_o, pa0_oe_n, pa3, pa3_oe_n, pa4_o, pa4_oe_n, wake, pa0, pa4, cmp;
	int          miscompares = 0, cmp_count = 0;
	always #2.5 clk = ~clk;
	always #20 fast = ~fast;
	always #50 slow = ~slow;
	always #62.5 alt = ~alt;
	always #10 x2 = ~x2;
	tpc_timer i_dut (.i_sys_clk(clk), .i_nrst(nrst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
		.i_fast_internal_osc(fast), .i_fast_osc_x2(x2), .i_slow_internal_osc(slow), .i_alt_slow_osc(alt),
		.i_cmp_result(cmp), .i_port_a_bit_zero(pa0), .i_port_a_bit_four(pa4), .o_port_a_bit_zero(pa0_o),
		.o_port_a_bit_zero_oe_n(pa0_oe_n), .o_port_a_bit_three(pa3), .o_port_a_bit_three_oe_n(pa3_oe_n),
		.o_port_a_bit_four(pa4_o), .o_port_a_bit_four_oe_n(pa4_oe_n), .o_wake(wake));
	tpc_pins i_pins (.i_sys_clk(clk), .i_pa0_out(pa0_o), .i_pa0_oe_n(pa0_oe_n), .i_pa4_out(pa4_o),
		.i_pa4_oe_n(pa4_oe_n), .o_pa0(pa0), .o_pa4(pa4), .o_cmp(cmp));
	task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		cmp_count++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			miscompares++;
			$display("ERROR %0t got %h exp %h..%h", $time, got, lo, hi);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		addr <= a;
		wdata <= {24'h00_0000, d};
		wr <= w;
		rd <= ~w;
		// Only the watchdog ends a wait that never answers
		do begin
			@(posedge clk);
		end while (waitreq !== 1'b0);
		q = rdata[7:0];
		wr <= 1'b0;
		rd <= 1'b0;
		// Gap cycle so every request starts fresh
		@(posedge clk);
	endtask
	task automatic cnt(input int n, input logic wk, output int hi, output int tg);
		logic s, p;
		hi = 0;
		tg = 0;
		p = wk ? wake : pa3;
		repeat (n) begin
			@(posedge clk);
			s = wk ? wake : pa3;
			hi += (s === 1'b1);
			tg += (s !== p);
			p = s;
		end
	endtask
	task automatic t_regs;
		logic [7:0] q;
		logic [7:0] a [8] = '{8'h09, 8'h17, 8'h19, 8'h1c, 8'h1d, 8'h18, 8'h1f, 8'h00};
		foreach (a[i]) begin
			bus(0, a[i], 8'h00, q);
			chk(q, 0, 0);
		end
		chk({pa0_oe_n, pa3_oe_n, pa4_oe_n}, 7, 7);
		bus(1, 8'h00, 8'hff, q);
		bus(1, 8'h09, 8'hff, q);
		bus(0, 8'h09, 8'h00, q);
		chk(q, 0, 0);
		be <= 4'h0;
		bus(1, 8'h1d, 8'ha5, q);
		be <= 4'hf;
		bus(0, 8'h1d, 8'h00, q);
		chk(q, 0, 0);
		bus(1, 8'h1d, 8'ha5, q);
		bus(0, 8'h1d, 8'h00, q);
		chk(q, 8'ha5, 8'ha5);
		$display("t_regs done");
	endtask
	task automatic t_clk;
		logic [7:0] q, q2;
		logic [7:0] c [6] = '{8'h10, 8'h20, 8'h40, 8'h60, 8'h10, 8'h10};
		logic [7:0] s [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h21, 8'h60};
		int lo [6] = '{202, 24, 9, 7, 24, 2};
		bus(1, 8'h09, 8'hff, q);
		foreach (c[i]) begin
			bus(1, 8'h17, s[i], q);
			bus(1, 8'h1d, 8'h00, q);
			bus(1, 8'h1c, c[i], q);
			repeat (200) @(posedge clk);
			bus(1, 8'h1c, 8'h00, q);
			bus(0, 8'h1d, 8'h00, q);
			chk(q, lo[i], lo[i] + 2);
			repeat (20) @(posedge clk);
			bus(0, 8'h1d, 8'h00, q2);
			chk(q2, q, q);
		end
		$display("t_clk done");
	endtask
	task automatic t_edges;
		logic [7:0] q;
		logic [7:0] c [5] = '{8'h80, 8'h90, 8'hc0, 8'hd0, 8'h50};
		int p [5] = '{0, 0, 1, 1, 2};
		bus(1, 8'h17, 8'h00, q);
		foreach (c[i]) begin
			bus(1, 8'h1d, 8'h00, q);
			bus(1, 8'h1c, c[i], q);
			i_pins.pulse(p[i], 5);
			repeat (10) @(posedge clk);
			bus(1, 8'h1c, 8'h00, q);
			bus(0, 8'h1d, 8'h00, q);
			chk(q, 5, 5);
		end
		$display("t_edges done");
	endtask
	task automatic t_out;
		logic [7:0] q;
		logic v;
		int hi, tg;
		bus(1, 8'h1d, 8'h00, q);
		bus(1, 8'h09, 8'h03, q);
		bus(1, 8'h1c, 8'h18, q);
		cnt(80, 1'b0, hi, tg);
		chk(tg, 19, 21);
		chk({pa3_oe_n, pa4_oe_n}, 1, 1);
		bus(1, 8'h1c, 8'h0c, q);
		@(posedge clk);
		chk({pa3_oe_n, pa4_oe_n}, 2, 2);
		bus(1, 8'h1c, 8'h04, q);
		@(posedge clk);
		chk({pa3_oe_n, pa4_oe_n}, 3, 3);
		bus(1, 8'h1c, 8'h08, q);
		@(posedge clk);
		v = pa3;
		bus(1, 8'h1c, 8'h09, q);
		@(posedge clk);
		chk(pa3 ^ v, 1, 1);
		bus(0, 8'h1f, 8'h00, q);
		chk(q[0], v, v);
		bus(1, 8'h1c, 8'h0d, q);
		@(posedge clk);
		chk(pa4, !v, !v);
		bus(1, 8'h09, 8'h40, q);
		bus(1, 8'h1c, 8'h1a, q);
		repeat (300) @(posedge clk);
		cnt(512, 1'b0, hi, tg);
		chk(hi, 128, 128);
		bus(1, 8'h17, 8'h80, q);
		bus(1, 8'h09, 8'h10, q);
		repeat (300) @(posedge clk);
		cnt(128, 1'b0, hi, tg);
		chk(hi, 32, 32);
		bus(1, 8'h1c, 8'h00, q);
		$display("t_out done");
	endtask
	task automatic t_cmp;
		logic [7:0] q;
		int hi, tg;
		bus(1, 8'h19, 8'h80, q);
		i_pins.set_cmp(1'b1);
		repeat (10) @(posedge clk);
		chk({pa0_oe_n, pa0_o}, 1, 1);
		bus(1, 8'h19, 8'hc0, q);
		i_pins.set_cmp(1'b0);
		cnt(12, 1'b1, hi, tg);
		chk(hi, 1, 1);
		bus(1, 8'h19, 8'h80, q);
		i_pins.set_cmp(1'b1);
		cnt(12, 1'b1, hi, tg);
		chk(hi, 0, 0);
		bus(1, 8'h18, 8'h20, q);
		i_pins.set_cmp(1'b0);
		repeat (10) @(posedge clk);
		chk(pa0_o, 1, 1);
		bus(1, 8'h1c, 8'h10, q);
		repeat (10) @(posedge clk);
		chk(pa0_o, 0, 0);
		$display("t_cmp done");
	endtask
	// Reset in mid-run, with every register and the port A bit 0 pin away from its reset value
	task automatic t_rst;
		logic [7:0] q;
		nrst <= 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk({pa0_oe_n, pa3_oe_n, pa4_oe_n}, 7, 7);
		bus(0, 8'h1c, 8'h00, q);
		chk(q, 0, 0);
		bus(0, 8'h1d, 8'h00, q);
		chk(q, 0, 0);
		bus(0, 8'h18, 8'h00, q);
		chk(q, 0, 0);
		$display("t_rst done");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_regs;
		t_clk;
		t_edges;
		t_out;
		t_cmp;
		t_rst;
		wrap_up;
	end
	// Tests need about 3200 cycles; 50000 means a hang
	initial begin
		#250000;
		miscompares++;
		wrap_up;
	end
endmodule // tpc_timer_tb
`default_nettype wire
